// file: bsc_pkg.sv
// ==========================================================
// Chain geometry
package bsc_pkg;

    localparam int unsigned BSC_LEN       = 281;
    localparam int unsigned BSC_TOP       = 280;
    localparam int unsigned BSC_RSVD_BIT  = 0;
    localparam int unsigned BSC_CLK_BIT   = 139;
    localparam int unsigned BSC_SYNC_STGS = 2;
    localparam int unsigned BSC_N_IN      = 25;

    typedef logic [BSC_LEN-1:0] bsc_vec_t;

    // Pin-facing group, indexed by chain position
    typedef struct packed {
        bsc_vec_t lvl;
        bsc_vec_t dat;
        bsc_vec_t oe;
    } bsc_pins_t;

    // Cells with a single input-only bit, reserved bit included
    localparam int unsigned BSC_IN_CELLS [BSC_N_IN] = '{
        210, 209, 208, 207, 206, 205, 204, 203, 202, 201, 200, 199, 198, 197,
        164, 139, 128, 123, 118, 117, 108, 103, 90, 79, 0
    };

    localparam bsc_vec_t BSC_RST_VEC = '0;

    // ==========================================================
    // Cell classification
    function automatic bsc_vec_t bsc_in_mask();
        bsc_vec_t m;
        m = '0;
        for (int k = 0; k < BSC_N_IN; k++) begin
            m[BSC_IN_CELLS[k]] = 1'b1;
        end
        return m;
    endfunction

    // Enable bit of each driven pin sits directly above its value bit
    function automatic bsc_vec_t bsc_en_mask();
        bsc_vec_t m;
        bsc_vec_t inm;
        int       i;
        m   = '0;
        inm = bsc_in_mask();
        i   = BSC_TOP;
        while (i > 0) begin
            if (inm[i]) begin
                i = i - 1;
            end else begin
                m[i] = 1'b1;
                i    = i - 2;
            end
        end
        return m;
    endfunction

    localparam bsc_vec_t BSC_IN_MASK  = bsc_in_mask();
    localparam bsc_vec_t BSC_EN_MASK  = bsc_en_mask();
    localparam bsc_vec_t BSC_DAT_MASK = ~(BSC_IN_MASK | BSC_EN_MASK);

endpackage

// file: bsc_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Two-stage level synchroniser
module bsc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    initial begin
        if (W < 1) $error("bsc_sync width must be at least 1");
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: bsc_chain.sv
// Behaviour
// - Capture loads chain only when selected and in Capture-DR.
// - SAMPLE/PRELOAD capture records every input, output and bidirectional pin.
// - Bidirectional pin sampled as output if enable is 1, else input.
// - EXTEST capture records input levels only; bidirectionals read as inputs.
// - Shift-DR moves chain toward serial out; bit 280 takes serial in.
// - Update-DR copies chain to output register, held otherwise.
// - Under EXTEST, enabled output and bidirectional pins driven from output register.
// - Fixed order: bit 280 first enable, enable above value, 139 clock, 0 reserved.
// - Chain is 281 bits, in at bit 280, out from bit 0.
// - Enable cell 0 floats the pin, 1 drives it.
`timescale 1ns/10ps
`default_nettype none
module bsc_chain #(
    parameter int unsigned LEN = bsc_pkg::BSC_LEN
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               tck,
    input  wire logic               tck_rst,
    input  wire logic               sel_bsr,
    input  wire logic               ir_extest,
    input  wire logic               ir_sample,
    input  wire logic               capture_dr,
    input  wire logic               shift_dr,
    input  wire logic               update_dr,
    input  wire logic               tdi,
    output logic                    tdo,
    input  wire bsc_pkg::bsc_pins_t core_pins,
    output bsc_pkg::bsc_vec_t       pad_dat,
    output bsc_pkg::bsc_vec_t       pad_oe,
    output logic                    extest_on
);
    // ==========================================================
    // Elaboration checks on the fixed geometry
    initial begin
        if (LEN != bsc_pkg::BSC_LEN) $error("bsc_chain supports only the fixed chain length");
        if (bsc_pkg::BSC_SYNC_STGS != 2) $error("bsc_chain synchronisers have two stages");
        if (bsc_pkg::BSC_EN_MASK[bsc_pkg::BSC_TOP] != 1'b1) begin
            $error("bsc_chain top cell must be an enable cell");
        end
        if (bsc_pkg::BSC_IN_MASK[bsc_pkg::BSC_CLK_BIT] != 1'b1) begin
            $error("bsc_chain bus clock cell must be input-only");
        end
        if (bsc_pkg::BSC_IN_MASK[bsc_pkg::BSC_RSVD_BIT] != 1'b1) begin
            $error("bsc_chain reserved cell must be a single bit");
        end
        if ((bsc_pkg::BSC_IN_MASK & bsc_pkg::BSC_EN_MASK) != '0) begin
            $error("bsc_chain cell classes overlap");
        end
    end

    // ==========================================================
    // Pin and core levels into the test clock domain
    bsc_pkg::bsc_pins_t pins_t;
    bsc_pkg::bsc_vec_t  sh_r;
    bsc_pkg::bsc_vec_t  upd_r;
    bsc_pkg::bsc_vec_t  cap_nxt;
    logic               upd_tgl_r;
    logic               cap_go;
    logic               shf_go;
    logic               upd_go;

    bsc_sync #(.W($bits(bsc_pkg::bsc_pins_t))) u_pin_sync (
        .clk (tck),
        .rst (tck_rst),
        .d   (core_pins),
        .q   (pins_t)
    );

    // ==========================================================
    // Operation strobes decoded from the controller state
    assign cap_go = sel_bsr && capture_dr && (ir_sample || ir_extest);
    assign shf_go = sel_bsr && shift_dr;
    assign upd_go = sel_bsr && update_dr;

    // ==========================================================
    // Capture values per cell class
    for (genvar i = 0; i < bsc_pkg::BSC_LEN; i++) begin : g_cap
        if (i == bsc_pkg::BSC_RSVD_BIT) begin : g_rsvd
            assign cap_nxt[i] = 1'b0;
        end else if (bsc_pkg::BSC_IN_MASK[i]) begin : g_in
            assign cap_nxt[i] = pins_t.lvl[i];
        end else if (bsc_pkg::BSC_EN_MASK[i]) begin : g_en
            // Enable cell keeps its bit under the external test
            assign cap_nxt[i] = ir_sample ? pins_t.oe[i-1] : sh_r[i];
        end else begin : g_dat
            logic smp_v;
            assign smp_v      = pins_t.oe[i] ? pins_t.dat[i] : pins_t.lvl[i];
            assign cap_nxt[i] = ir_sample ? smp_v
                              : (ir_extest ? pins_t.lvl[i] : sh_r[i]);
        end
    end

    // ==========================================================
    // Shift register
    always_ff @(posedge tck) begin
        if (tck_rst) begin
            sh_r <= bsc_pkg::BSC_RST_VEC;
        end else if (cap_go) begin
            sh_r <= cap_nxt;
        end else if (shf_go) begin
            sh_r <= {tdi, sh_r[bsc_pkg::BSC_TOP:1]};
        end
    end

    // Serial out changes on the falling edge
    always_ff @(negedge tck) begin
        if (tck_rst) begin
            tdo <= 1'b0;
        end else if (shf_go) begin
            tdo <= sh_r[bsc_pkg::BSC_RSVD_BIT];
        end
    end

    // ==========================================================
    // Output register and update event
    always_ff @(posedge tck) begin
        if (tck_rst) begin
            upd_r     <= bsc_pkg::BSC_RST_VEC;
            upd_tgl_r <= 1'b0;
        end else if (upd_go) begin
            upd_r     <= sh_r;
            upd_tgl_r <= ~upd_tgl_r;
        end
    end

    // ==========================================================
    // Crossing into the core clock domain
    logic              tgl_s;
    logic              ext_s;
    logic              tgl_d_r;
    bsc_pkg::bsc_vec_t out_r;

    bsc_sync #(.W(2)) u_ctl_sync (
        .clk (clk),
        .rst (rst),
        .d   ({upd_tgl_r, ir_extest}),
        .q   ({tgl_s, ext_s})
    );

    // Output register word is stable for many core cycles after a toggle
    always_ff @(posedge clk) begin
        if (rst) begin
            tgl_d_r <= 1'b0;
            out_r   <= bsc_pkg::BSC_RST_VEC;
        end else begin
            tgl_d_r <= tgl_s;
            if (tgl_s != tgl_d_r) begin
                out_r <= upd_r;
            end
        end
    end

    // ==========================================================
    // Pad drive: test word under the external test, core values otherwise
    bsc_pkg::bsc_vec_t pad_dat_nxt;
    bsc_pkg::bsc_vec_t pad_oe_nxt;

    for (genvar i = 0; i < bsc_pkg::BSC_LEN; i++) begin : g_pad
        if (bsc_pkg::BSC_DAT_MASK[i]) begin : g_drv
            assign pad_dat_nxt[i] = ext_s ? out_r[i] : core_pins.dat[i];
            assign pad_oe_nxt[i]  = ext_s ? out_r[i+1] : core_pins.oe[i];
        end else begin : g_off
            // Enable, input and reserved cells never reach a pad
            assign pad_dat_nxt[i] = 1'b0;
            assign pad_oe_nxt[i]  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pad_dat   <= bsc_pkg::BSC_RST_VEC;
            pad_oe    <= bsc_pkg::BSC_RST_VEC;
            extest_on <= 1'b0;
        end else begin
            pad_dat   <= pad_dat_nxt;
            pad_oe    <= pad_oe_nxt;
            extest_on <= ext_s;
        end
    end
endmodule
`default_nettype wire

// file: bsc_chain_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checks
module bsc_chain_checker (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               tck,
    input wire logic               tck_rst,
    input wire logic               sel_bsr,
    input wire logic               ir_extest,
    input wire logic               shift_dr,
    input wire logic               update_dr,
    input wire logic               tdo,
    input wire bsc_pkg::bsc_pins_t core_pins,
    input wire bsc_pkg::bsc_vec_t  pad_dat,
    input wire bsc_pkg::bsc_vec_t  pad_oe,
    input wire logic               extest_on
);
    localparam bsc_pkg::bsc_vec_t DM = bsc_pkg::BSC_DAT_MASK;
    ext_on_a: assert property (@(posedge clk) disable iff (rst)
        ir_extest [*6] |-> extest_on) else $error("ext on");
    ext_off_a: assert property (@(posedge clk) disable iff (rst)
        !ir_extest [*6] |-> !extest_on) else $error("ext off");
    core_dat_a: assert property (@(posedge clk) disable iff (rst)
        !extest_on [*4] |-> pad_dat == ($past(core_pins.dat) & DM)) else $error("dat");
    core_oe_a: assert property (@(posedge clk) disable iff (rst)
        !extest_on [*4] |-> pad_oe == ($past(core_pins.oe) & DM)) else $error("oe");
    pad_hold_a: assert property (@(posedge clk) disable iff (rst)
        (extest_on && ir_extest && !update_dr) [*8] |=> $stable(pad_dat) && $stable(pad_oe))
        else $error("hold");
    pad_mask_a: assert property (@(posedge clk) disable iff (rst)
        ((pad_dat | pad_oe) & ~DM) == '0) else $error("mask");
    rst_off_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> !extest_on && pad_oe == '0) else $error("reset");
    tdo_hold_a: assert property (@(negedge tck) disable iff (tck_rst)
        !(sel_bsr && shift_dr) |=> $stable(tdo)) else $error("tdo");
    cover property (@(posedge clk) $rose(extest_on));
    cover property (@(negedge tck) sel_bsr && shift_dr);
    cover property (@(posedge tck) sel_bsr && update_dr);
endmodule
`default_nettype wire

// file: bsc_tester.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Scan tester, clock stopped between frames
module bsc_tester (
    output logic      tck,
    output logic      tck_rst,
    output logic      sel_bsr,
    output logic      ir_extest,
    output logic      ir_sample,
    output logic      capture_dr,
    output logic      shift_dr,
    output logic      update_dr,
    output logic      tdi,
    input  wire logic tdo
);
    // One test clock period; tdo read before the rise, next state launched on it
    task automatic step(input logic [3:0] ctl, output logic seen);
        #80 seen = tdo;
        tck = 1'b1;
        {capture_dr, shift_dr, update_dr, tdi} <= ctl;
        #80 tck = 1'b0;
    endtask
    task automatic scan(input logic ext, input bsc_pkg::bsc_vec_t din,
                        output bsc_pkg::bsc_vec_t dout);
        logic drop;
        {sel_bsr, ir_extest, ir_sample} <= {1'b1, ext, !ext};
        repeat (2) step(4'h0, drop);
        step(4'h8, drop);
        step({3'h2, din[0]}, drop);
        for (int k = 0; k < bsc_pkg::BSC_LEN - 1; k++) begin
            step({3'h2, din[k+1]}, dout[k]);
        end
        step(4'h2, dout[bsc_pkg::BSC_TOP]);
        step(4'h0, drop);
    endtask
    initial begin
        {tck, sel_bsr, ir_extest, ir_sample, capture_dr, shift_dr, update_dr, tdi} = '0;
        tck_rst = 1'b1;
        repeat (3) begin
            #80 tck = 1'b1;
            #80 tck = 1'b0;
        end
        tck_rst <= 1'b0;
    end
endmodule
`default_nettype wire

// file: boundary_scan_cell_chain_tb.sv
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_cell_chain_tb;
    logic               clk, rst, tck, tck_rst, sel_bsr, ir_extest, ir_sample;
    logic               capture_dr, shift_dr, update_dr, tdi, tdo, extest_on;
    bsc_pkg::bsc_pins_t core_pins;
    bsc_pkg::bsc_vec_t  pad_dat, pad_oe, a, b, r, cap, eq[$], gq[$];
    int                 fails, check_count, cyc, seed;
    localparam bsc_pkg::bsc_vec_t DM = bsc_pkg::BSC_DAT_MASK;
    localparam bsc_pkg::bsc_vec_t EM = bsc_pkg::BSC_EN_MASK;
    localparam bsc_pkg::bsc_vec_t IM = (bsc_pkg::BSC_IN_MASK >> 1) << 1;
    bsc_chain dut (
        .clk        (clk),
        .rst        (rst),
        .tck        (tck),
        .tck_rst    (tck_rst),
        .sel_bsr    (sel_bsr),
        .ir_extest  (ir_extest),
        .ir_sample  (ir_sample),
        .capture_dr (capture_dr),
        .shift_dr   (shift_dr),
        .update_dr  (update_dr),
        .tdi        (tdi),
        .tdo        (tdo),
        .core_pins  (core_pins),
        .pad_dat    (pad_dat),
        .pad_oe     (pad_oe),
        .extest_on  (extest_on)
    );
    bsc_tester tst (
        .tck        (tck),
        .tck_rst    (tck_rst),
        .sel_bsr    (sel_bsr),
        .ir_extest  (ir_extest),
        .ir_sample  (ir_sample),
        .capture_dr (capture_dr),
        .shift_dr   (shift_dr),
        .update_dr  (update_dr),
        .tdi        (tdi),
        .tdo        (tdo)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic bsc_pkg::bsc_vec_t rnd();
        bsc_pkg::bsc_vec_t v;
        v = '0;
        repeat (9) v = bsc_pkg::bsc_vec_t'({v, $random(seed)});
        return v;
    endfunction
    task automatic note(input bsc_pkg::bsc_vec_t want, input bsc_pkg::bsc_vec_t seen);
        eq.push_back(want);
        gq.push_back(seen);
    endtask
    task automatic chk(input bsc_pkg::bsc_vec_t seen, input bsc_pkg::bsc_vec_t want);
        check_count++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial forever begin
        wait (gq.size() > 0);
        chk(gq.pop_front(), eq.pop_front());
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        seed = 32'h5D4920DA;
        fails = 0;
        check_count = 0;
        cyc = 0;
        rst = 1'b1;
        core_pins = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        core_pins <= {rnd(), rnd(), rnd()};
        repeat (4) @(negedge clk);
        cap = (core_pins.lvl & IM) | ((core_pins.oe << 1) & EM)
            | (DM & ((core_pins.oe & core_pins.dat) | (~core_pins.oe & core_pins.lvl)));
        a = rnd();
        tst.scan(1'b0, a, r);
        note(cap, r);
        repeat (8) @(negedge clk);
        note(core_pins.dat & DM, pad_dat);
        note(core_pins.oe & DM, pad_oe);
        note('0, bsc_pkg::bsc_vec_t'(extest_on));
        b = rnd();
        tst.scan(1'b1, b, r);
        note((a & EM) | (core_pins.lvl & (DM | IM)), r);
        repeat (8) @(negedge clk);
        note(b & DM, pad_dat);
        note((b >> 1) & DM, pad_oe);
        note(bsc_pkg::bsc_vec_t'(1'b1), bsc_pkg::bsc_vec_t'(extest_on));
        @(posedge clk);
        give_verdict();
    end
endmodule
bind bsc_chain bsc_chain_checker mon (
    .clk       (clk),
    .rst       (rst),
    .tck       (tck),
    .tck_rst   (tck_rst),
    .sel_bsr   (sel_bsr),
    .ir_extest (ir_extest),
    .shift_dr  (shift_dr),
    .update_dr (update_dr),
    .tdo       (tdo),
    .core_pins (core_pins),
    .pad_dat   (pad_dat),
    .pad_oe    (pad_oe),
    .extest_on (extest_on)
);
`default_nettype wire
